// >>> common/acsc_defines.vh
/*
 Register map, field positions, reset values and sequencer counts of the
 comparator and converter control block. Assumes a 32-bit Avalon-MM slave
 with byte addresses whose two low bits are ignored.
*/
`ifndef ACSC_DEFINES_VH
`define ACSC_DEFINES_VH

// ----------------------------------------------------------------------
// Register word indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define ACSC_IDX_CMP_CTRL   3'h0
`define ACSC_IDX_SPECIAL    3'h1
`define ACSC_IDX_INPUT_SEL  3'h2
`define ACSC_IDX_CONV_CTRL  3'h3
`define ACSC_IDX_RES_LOW    3'h4
`define ACSC_IDX_RES_HIGH   3'h5

// ----------------------------------------------------------------------
// Comparator control and status fields
// ----------------------------------------------------------------------
`define ACSC_CMP_OUT_BIT    5
`define ACSC_CMP_FLAG_BIT   4
`define ACSC_CMP_IE_BIT     3
`define ACSC_CMP_ROUTE_BIT  2
`define ACSC_CMP_EDGE_HI    1
`define ACSC_CMP_EDGE_LO    0
`define ACSC_EDGE_TOGGLE    2'h0
`define ACSC_EDGE_FALL      2'h2
`define ACSC_EDGE_RISE      2'h3

// ----------------------------------------------------------------------
// Special function, input select and converter control fields
// ----------------------------------------------------------------------
`define ACSC_MUX_EN_BIT     3
`define ACSC_REF_HI         7
`define ACSC_REF_LO         6
`define ACSC_LADJ_BIT       5
`define ACSC_CH_HI          2
`define ACSC_CH_LO          0
`define ACSC_EN_BIT         7
`define ACSC_START_BIT      6
`define ACSC_FREE_BIT       5
`define ACSC_DONE_BIT       4
`define ACSC_CIE_BIT        3
`define ACSC_DIV_HI         2
`define ACSC_DIV_LO         0

// ----------------------------------------------------------------------
// Reset values and sequencer counts (converter clock cycles)
// ----------------------------------------------------------------------
`define ACSC_RST_BYTE       8'h00
`define ACSC_RST_RESULT     10'h000
`define ACSC_LEN_NORMAL     5'h0D
`define ACSC_LEN_FIRST      5'h19
`define ACSC_SH_NORMAL      5'h01
`define ACSC_SH_FIRST       5'h0D

`endif

// >>> src/acsc_sync.v
/*
 Two-stage synchroniser for a single level.
 Assumes the input may change at any time relative to sys_clk_in.
*/
`timescale 1ns/100ps
`default_nettype none

module acsc_sync (
   // Clock and reset
   input  wire sys_clk_in,
   input  wire resetn_in,
   // Level
   input  wire async_in,
   output reg  sync_out
);

   reg meta_r;

   // ----------------------------------------------------------------------
   // Synchroniser stages
   // ----------------------------------------------------------------------
   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta_r   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule // acsc_sync

`default_nettype wire

// >>> src/acsc_prescaler.v
/*
 Converter clock prescaler: divides the system clock by 2 to 128 and
 gives one-cycle pulses at the converter clock's rising and falling edges.
 Assumes enable comes from a register in the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module acsc_prescaler #(
   parameter CNT_W = 7
) (
   // Clock and reset
   input  wire       sys_clk_in,
   input  wire       resetn_in,
   // Control
   input  wire       enable_in,
   input  wire [2:0] div_sel_in,
   // Converter clock
   output reg        rise_out,
   output reg        fall_out,
   output reg        clk_out
);

   reg  [CNT_W-1:0] cnt_r;
   wire [CNT_W-1:0] mask;
   wire [CNT_W-1:0] half;

   assign mask = (div_sel_in < 3'h2) ? {{(CNT_W-1){1'b0}}, 1'b1} :
                 ((({{(CNT_W-1){1'b0}}, 1'b1}) << div_sel_in) - {{(CNT_W-1){1'b0}}, 1'b1});
   assign half = mask >> 1;

   // ----------------------------------------------------------------------
   // Counter and edge pulses
   // ----------------------------------------------------------------------
   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_r    <= {CNT_W{1'b0}};
         rise_out <= 1'b0;
         fall_out <= 1'b0;
         clk_out  <= 1'b0;
      end else if (!enable_in) begin
         cnt_r    <= {CNT_W{1'b0}};
         rise_out <= 1'b0;
         fall_out <= 1'b0;
         clk_out  <= 1'b0;
      end else begin
         cnt_r    <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
         rise_out <= ((cnt_r & mask) == mask);
         fall_out <= ((cnt_r & mask) == half);
         if ((cnt_r & mask) == mask)
            clk_out <= 1'b1;
         else if ((cnt_r & mask) == half)
            clk_out <= 1'b0;
      end
   end

endmodule // acsc_prescaler

`default_nettype wire

// >>> src/acsc_top.v
/*
 Comparator control and converter conversion sequencer behind an
 Avalon-MM slave with waitrequest. Assumes the comparator output and the
 converter result arrive synchronous or are synchronised here, and that
 the converter core samples when conv_sample_out pulses.
*/
`timescale 1ns/100ps
`default_nettype none
`include "acsc_defines.vh"

module acsc_top (
   // Clock and reset
   input  wire        sys_clk_in,
   input  wire        resetn_in,
   // Avalon-MM slave
   input  wire [4:0]  address_in,
   input  wire        read_in,
   input  wire        write_in,
   input  wire [31:0] writedata_in,
   input  wire [3:0]  byteenable_in,
   output reg  [31:0] readdata_out,
   output reg         waitrequest_out,
   // CPU interrupt handshake
   input  wire        global_irq_enable_in,
   input  wire        comp_vector_taken_in,
   input  wire        conv_vector_taken_in,
   output reg         comp_irq_req_out,
   output reg         conv_irq_req_out,
   // Analog comparator
   input  wire        comp_raw_in,
   output reg         comp_capture_out,
   output reg         comp_neg_mux_out,
   output reg  [2:0]  comp_neg_ch_out,
   // Converter core
   input  wire [9:0]  conv_result_in,
   output reg         conv_enable_out,
   output reg  [2:0]  conv_ch_out,
   output reg  [1:0]  conv_ref_out,
   output reg         conv_sample_out,
   output reg         conv_busy_out,
   output reg         conv_clk_out
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   reg        cmp_ie_r;
   reg        cmp_route_r;
   reg  [1:0] cmp_edge_r;
   reg        cmp_flag_r;
   reg        cmp_prev_r;
   reg        mux_en_r;
   reg  [1:0] ref_sel_r;
   reg        left_adj_r;
   reg  [2:0] chan_sel_r;
   reg  [2:0] act_ch_r;
   reg  [1:0] act_ref_r;
   reg        adc_en_r;
   reg        start_r;
   reg        free_r;
   reg        done_r;
   reg        conv_ie_r;
   reg  [2:0] div_r;
   reg        pend_r;
   reg        busy_r;
   reg        first_r;
   reg  [4:0] cyc_r;
   reg        lock_r;
   reg  [9:0] res_r;
   reg        cmp_event;
   reg  [7:0] rd_byte;
   wire       cmp_sync;
   wire       tick_rise;
   wire       tick_fall;
   wire       pclk;
   wire       wr_acc;
   wire       rd_acc;
   wire [2:0] idx;
   wire [7:0] wd;
   wire [4:0] len;
   wire [4:0] sh_cyc;
   wire       last_cyc;
   wire       complete;
   wire       cmp_flag_nxt;
   wire       done_nxt;
   wire       start_wr;

   assign idx      = address_in[4:2];
   assign wd       = writedata_in[7:0];
   assign wr_acc   = write_in & ~waitrequest_out & byteenable_in[0];
   assign rd_acc   = read_in & ~waitrequest_out;
   assign len      = first_r ? `ACSC_LEN_FIRST : `ACSC_LEN_NORMAL;
   assign sh_cyc   = first_r ? `ACSC_SH_FIRST : `ACSC_SH_NORMAL;
   assign last_cyc = busy_r & (cyc_r == len - 5'h01);
   assign complete = tick_rise & last_cyc;
   assign start_wr = wr_acc & (idx == `ACSC_IDX_CONV_CTRL) & wd[`ACSC_START_BIT] & wd[`ACSC_EN_BIT];

   function [7:0] res_byte;
      input       hi;
      input       ladj;
      input [9:0] r;
      begin
         if (ladj)
            res_byte = hi ? r[9:2] : {r[1:0], 6'h00};
         else
            res_byte = hi ? {6'h00, r[9:8]} : r[7:0];
      end
   endfunction

   // ----------------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------------
   // comparator synchroniser
   acsc_sync u_cmp_sync (
      .sys_clk_in (sys_clk_in),
      .resetn_in  (resetn_in),
      .async_in   (comp_raw_in),
      .sync_out   (cmp_sync)
   );

   acsc_prescaler #(.CNT_W(7)) u_presc (
      .sys_clk_in (sys_clk_in),
      .resetn_in  (resetn_in),
      .enable_in  (adc_en_r),
      .div_sel_in (div_r),
      .rise_out   (tick_rise),
      .fall_out   (tick_fall),
      .clk_out    (pclk)
   );

   // ----------------------------------------------------------------------
   // Comparator edge detection
   // ----------------------------------------------------------------------
   always @* begin
      case (cmp_edge_r)
         `ACSC_EDGE_TOGGLE: cmp_event = cmp_sync ^ cmp_prev_r;
         `ACSC_EDGE_FALL:   cmp_event = cmp_prev_r & ~cmp_sync;
         `ACSC_EDGE_RISE:   cmp_event = ~cmp_prev_r & cmp_sync;
         default:           cmp_event = 1'b0;
      endcase
   end

   // set on chosen edge; clear, set wins
   assign cmp_flag_nxt = cmp_event |
                         (cmp_flag_r & ~comp_vector_taken_in &
                          ~(wr_acc & (idx == `ACSC_IDX_CMP_CTRL) & wd[`ACSC_CMP_FLAG_BIT]));

   // done flag set even when result discarded, set wins
   assign done_nxt = complete |
                     (done_r & ~conv_vector_taken_in &
                      ~(wr_acc & (idx == `ACSC_IDX_CONV_CTRL) & wd[`ACSC_DONE_BIT]));

   // ----------------------------------------------------------------------
   // Read data mux
   // ----------------------------------------------------------------------
   always @* begin
      case (idx)
         `ACSC_IDX_CMP_CTRL:  rd_byte = {2'h0, cmp_sync, cmp_flag_r, cmp_ie_r, cmp_route_r, cmp_edge_r};
         `ACSC_IDX_SPECIAL:   rd_byte = {4'h0, mux_en_r, 3'h0};
         `ACSC_IDX_INPUT_SEL: rd_byte = {ref_sel_r, left_adj_r, 2'h0, chan_sel_r};
         `ACSC_IDX_CONV_CTRL: rd_byte = {adc_en_r, start_r, free_r, done_r, conv_ie_r, div_r};
         `ACSC_IDX_RES_LOW:   rd_byte = res_byte(1'b0, left_adj_r, res_r);
         `ACSC_IDX_RES_HIGH:  rd_byte = res_byte(1'b1, left_adj_r, res_r);
         default:             rd_byte = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------------
   // Avalon handshake: one wait cycle, then acceptance
   // ----------------------------------------------------------------------
   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         waitrequest_out <= 1'b1;
         readdata_out    <= 32'h00000000;
      end else if ((read_in | write_in) & waitrequest_out) begin
         waitrequest_out <= 1'b0;
         readdata_out    <= {24'h000000, rd_byte};
      end else begin
         waitrequest_out <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Comparator registers and outputs
   // ----------------------------------------------------------------------
   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cmp_ie_r         <= 1'b0;
         cmp_route_r      <= 1'b0;
         cmp_edge_r       <= 2'h0;
         cmp_flag_r       <= 1'b0;
         cmp_prev_r       <= 1'b0;
         mux_en_r         <= 1'b0;
         comp_irq_req_out <= 1'b0;
         comp_capture_out <= 1'b0;
         comp_neg_mux_out <= 1'b0;
         comp_neg_ch_out  <= 3'h0;
      end else begin
         cmp_prev_r <= cmp_sync;
         cmp_flag_r <= cmp_flag_nxt;
         if (wr_acc & (idx == `ACSC_IDX_CMP_CTRL)) begin
            cmp_ie_r    <= wd[`ACSC_CMP_IE_BIT];
            cmp_route_r <= wd[`ACSC_CMP_ROUTE_BIT];
            cmp_edge_r  <= wd[`ACSC_CMP_EDGE_HI:`ACSC_CMP_EDGE_LO];
         end
         if (wr_acc & (idx == `ACSC_IDX_SPECIAL))
            mux_en_r <= wd[`ACSC_MUX_EN_BIT];
         comp_irq_req_out <= cmp_flag_nxt & cmp_ie_r & global_irq_enable_in;
         comp_capture_out <= cmp_route_r & cmp_sync;
         comp_neg_mux_out <= mux_en_r & ~adc_en_r;
         comp_neg_ch_out  <= (mux_en_r & ~adc_en_r) ? chan_sel_r : 3'h0;
      end
   end

   // ----------------------------------------------------------------------
   // Input select register and active selection
   // ----------------------------------------------------------------------
   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ref_sel_r  <= 2'h0;
         left_adj_r <= 1'b0;
         chan_sel_r <= 3'h0;
         act_ch_r   <= 3'h0;
         act_ref_r  <= 2'h0;
      end else begin
         if (wr_acc & (idx == `ACSC_IDX_INPUT_SEL)) begin
            ref_sel_r  <= wd[`ACSC_REF_HI:`ACSC_REF_LO];
            left_adj_r <= wd[`ACSC_LADJ_BIT];
            chan_sel_r <= wd[`ACSC_CH_HI:`ACSC_CH_LO];
         end
         // track when idle or in last cycle; frozen mid-conversion
         if (~busy_r | last_cyc) begin
            act_ch_r  <= chan_sel_r;
            act_ref_r <= ref_sel_r;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Converter control and sequencer
   // ----------------------------------------------------------------------
   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         adc_en_r  <= 1'b0;
         start_r   <= 1'b0;
         free_r    <= 1'b0;
         done_r    <= 1'b0;
         conv_ie_r <= 1'b0;
         div_r     <= 3'h0;
         pend_r    <= 1'b0;
         busy_r    <= 1'b0;
         first_r   <= 1'b1;
         cyc_r     <= 5'h00;
      end else begin
         done_r <= done_nxt;
         if (wr_acc & (idx == `ACSC_IDX_CONV_CTRL)) begin
            adc_en_r  <= wd[`ACSC_EN_BIT];
            free_r    <= wd[`ACSC_FREE_BIT];
            conv_ie_r <= wd[`ACSC_CIE_BIT];
            div_r     <= wd[`ACSC_DIV_HI:`ACSC_DIV_LO];
         end
         if (!adc_en_r) begin
            // Disabled: abort, arm first conversion, take an enabling start
            start_r <= start_wr;
            pend_r  <= start_wr;
            busy_r  <= 1'b0;
            first_r <= 1'b1;
            cyc_r   <= 5'h00;
         end else begin
            if (start_wr & ~start_r) begin
               start_r <= 1'b1;
               pend_r  <= 1'b1;
            end
            if (tick_rise) begin
               if (pend_r) begin
                  // begin at converter clock rising edge
                  pend_r <= 1'b0;
                  busy_r <= 1'b1;
                  cyc_r  <= 5'h00;
               end else if (complete) begin
                  // length reached; single mode clears start
                  first_r <= 1'b0;
                  cyc_r   <= 5'h00;
                  if (!free_r) begin
                     busy_r  <= 1'b0;
                     start_r <= 1'b0;
                  end
                  // free-run keeps busy and start high
               end else if (busy_r) begin
                  cyc_r <= cyc_r + 5'h01;
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Result register and read lock
   // ----------------------------------------------------------------------
   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         res_r  <= `ACSC_RST_RESULT;
         lock_r <= 1'b0;
      end else begin
         // lock on low read, release on high read
         if (rd_acc & (idx == `ACSC_IDX_RES_LOW))
            lock_r <= 1'b1;
         else if (rd_acc & (idx == `ACSC_IDX_RES_HIGH))
            lock_r <= 1'b0;
         // store the 10-bit result at completion unless locked
         if (complete & adc_en_r & ~lock_r)
            res_r <= conv_result_in;
      end
   end

   // ----------------------------------------------------------------------
   // Converter core outputs
   // ----------------------------------------------------------------------
   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         conv_enable_out  <= 1'b0;
         conv_ch_out      <= 3'h0;
         conv_ref_out     <= 2'h0;
         conv_sample_out  <= 1'b0;
         conv_busy_out    <= 1'b0;
         conv_clk_out     <= 1'b0;
         conv_irq_req_out <= 1'b0;
      end else begin
         conv_enable_out <= adc_en_r;
         conv_ch_out     <= adc_en_r ? act_ch_r : 3'h0;
         conv_ref_out    <= adc_en_r ? act_ref_r : 2'h0;
         // sample on the falling edge 1.5 or 13.5 cycles in
         conv_sample_out <= tick_fall & busy_r & (cyc_r == sh_cyc);
         conv_busy_out   <= busy_r;
         conv_clk_out    <= pclk;
         // request from done flag regardless of lock
         conv_irq_req_out <= done_nxt & conv_ie_r & global_irq_enable_in;
      end
   end

endmodule // acsc_top

`default_nettype wire

// >>> bench/acsc_top_sva.sv
/* Port checker for acsc_top: bus handshake, interrupt gating, comparator and
   converter sequencing. Bound to every acsc_top instance; sees ports only. */
`timescale 1ns/100ps
`default_nettype none
module acsc_top_sva (
   // Clock, reset and bus
   input wire logic       sys_clk_in,
   input wire logic       resetn_in,
   input wire logic       read_in,
   input wire logic       write_in,
   input wire logic       waitrequest_out,
   // Interrupts and comparator
   input wire logic       global_irq_enable_in,
   input wire logic       comp_raw_in,
   input wire logic       comp_capture_out,
   input wire logic       comp_irq_req_out,
   input wire logic       conv_irq_req_out,
   input wire logic       comp_neg_mux_out,
   input wire logic [2:0] comp_neg_ch_out,
   // Converter
   input wire logic       conv_enable_out,
   input wire logic [2:0] conv_ch_out,
   input wire logic [1:0] conv_ref_out,
   input wire logic       conv_sample_out,
   input wire logic       conv_busy_out,
   input wire logic       conv_clk_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   logic [4:0] rises_r;
   logic       clk_d_r;
   // Converter clock rises seen while busy
   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rises_r <= 5'h00;
         clk_d_r <= 1'h0;
      end else begin
         clk_d_r <= conv_clk_out;
         if (!conv_busy_out)
            rises_r <= 5'h00;
         else if (conv_clk_out && !clk_d_r)
            rises_r <= rises_r + 5'h01;
      end
   end
   AST_SYNC_LAT: assert property (
      $rose(comp_capture_out) |-> $past(comp_raw_in, 2) || $past(comp_raw_in, 3))
      else $error("capture rose without comparator level");
   AST_WAIT_ONE: assert property (
      (read_in || write_in) && waitrequest_out |=> !waitrequest_out ##1 waitrequest_out)
      else $error("access not answered after one wait cycle");
   AST_COMP_IRQ: assert property (comp_irq_req_out |-> $past(global_irq_enable_in))
      else $error("comparator request without global enable");
   AST_CONV_IRQ: assert property (conv_irq_req_out |-> $past(global_irq_enable_in))
      else $error("conversion request without global enable");
   AST_NEG_CH: assert property (!comp_neg_mux_out |-> comp_neg_ch_out == 3'h0)
      else $error("negative channel shown without mux");
   AST_NEG_OFF: assert property (
      conv_enable_out && $past(conv_enable_out) |-> !comp_neg_mux_out)
      else $error("mux used while converter enabled");
   AST_SEL_OFF: assert property (
      !conv_enable_out && !$past(conv_enable_out) |-> conv_ch_out == 3'h0 && conv_ref_out == 2'h0)
      else $error("selection applied while disabled");
   AST_CLK_HELD: assert property (!conv_enable_out && !$past(conv_enable_out) |-> !conv_clk_out)
      else $error("converter clock runs while disabled");
   AST_FROZEN: assert property ($rose(conv_busy_out) |=> $stable(conv_ch_out) [*8])
      else $error("channel changed early in conversion");
   AST_SAMPLE: assert property (conv_sample_out |-> conv_busy_out ##1 !conv_sample_out)
      else $error("sample pulse outside conversion or too long");
   AST_LEN: assert property (
      $fell(conv_busy_out) && conv_enable_out |-> rises_r inside {[5'h0C:5'h0E], [5'h18:5'h1A]})
      else $error("conversion length wrong");
   cover property ($rose(conv_busy_out));
   cover property (conv_sample_out);
   cover property ($rose(comp_irq_req_out));
endmodule // acsc_top_sva
bind acsc_top acsc_top_sva u_acsc_top_sva (.sys_clk_in, .resetn_in, .read_in, .write_in,
   .waitrequest_out, .global_irq_enable_in, .comp_raw_in, .comp_capture_out, .comp_irq_req_out,
   .conv_irq_req_out, .comp_neg_mux_out, .comp_neg_ch_out, .conv_enable_out, .conv_ch_out,
   .conv_ref_out, .conv_sample_out, .conv_busy_out, .conv_clk_out);
`default_nettype wire

// >>> bench/acsc_top_bench.sv
/* Self-checking bench for acsc_top: bus master, comparator and converter stimulus.
   Assumes the checker is bound in from its own file. */
`timescale 1ns/100ps
`default_nettype none
module acsc_top_bench;
   logic        clk, rst_n, rd_en, wr_en, gie, ctk, vtk, raw, er, ef, la;
   logic        wait_o, cirq, dirq, cap, nmux, en_o, smp, busy, cclk;
   logic [4:0]  addr;
   logic [31:0] wdata, rdata, r;
   logic [9:0]  res, r1, r2;
   logic [7:0]  cv;
   logic [2:0]  nch, ch_o, ch1, ch2;
   logic [1:0]  ref_o, rf;
   int          fails, samples_checked, p;
   acsc_top u_acsc_top (.sys_clk_in(clk), .resetn_in(rst_n), .address_in(addr), .read_in(rd_en),
      .write_in(wr_en), .writedata_in(wdata), .byteenable_in(4'hF), .readdata_out(rdata),
      .waitrequest_out(wait_o), .global_irq_enable_in(gie), .comp_vector_taken_in(ctk),
      .conv_vector_taken_in(vtk), .comp_irq_req_out(cirq), .conv_irq_req_out(dirq),
      .comp_raw_in(raw), .comp_capture_out(cap), .comp_neg_mux_out(nmux), .comp_neg_ch_out(nch),
      .conv_result_in(res), .conv_enable_out(en_o), .conv_ch_out(ch_o), .conv_ref_out(ref_o),
      .conv_sample_out(smp), .conv_busy_out(busy), .conv_clk_out(cclk));
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [2:0] idx, input logic [7:0] wd);
      rd_en <= !wr;
      wr_en <= wr;
      addr <= {idx, 2'h0};
      wdata <= {24'h0, wd};
      @(posedge clk);
      while (wait_o !== 1'h0) @(posedge clk);
      r = rdata;
      rd_en <= 1'h0;
      wr_en <= 1'h0;
      @(posedge clk);
   endtask
   task automatic wait_busy(input logic v);
      @(negedge clk);
      while (busy !== v) @(negedge clk);
      @(posedge clk);
   endtask
   task automatic wait_cclk(input logic v);
      while (cclk !== v) begin
         @(negedge clk);
         p++;
      end
   endtask
   function automatic logic [31:0] rb(input logic hi, input logic lj, input logic [9:0] v);
      logic [15:0] w;
      w = lj ? {v, 6'h00} : {6'h00, v};
      return {24'h0, hi ? w[15:8] : w[7:0]};
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      summarize();
   end
   initial begin
      {rst_n, rd_en, wr_en, gie, ctk, vtk, raw} = 7'h00;
      addr = 5'h00;
      wdata = 32'h0;
      res = 10'h000;
      fails = 0;
      samples_checked = 0;
      void'($urandom(53));
      repeat (16) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      gie <= 1'h1;
      for (int i = 0; i < 8; i++) begin
         bus(1'h0, i[2:0], 8'h00);
         check("reset read", r, 32'h0);
      end
      for (int m = 0; m < 4; m++) begin
         er = (m == 0 || m == 3);
         ef = (m == 0 || m == 2);
         cv = 8'h08 | m[7:0] | {5'h00, m[0], 2'h0};
         bus(1'h1, 3'h0, 8'h10 | m[7:0]);
         bus(1'h1, 3'h0, cv);
         raw <= 1'h1;
         repeat (6) @(posedge clk);
         check("cmp irq", cirq, er);
         check("capture", cap, m[0]);
         bus(1'h0, 3'h0, 8'h00);
         check("cmp rise", r, {24'h0, cv | 8'h20 | {3'h0, er, 4'h0}});
         ctk <= 1'h1;
         @(posedge clk);
         ctk <= 1'h0;
         raw <= 1'h0;
         repeat (6) @(posedge clk);
         bus(1'h0, 3'h0, 8'h00);
         check("cmp fall", r, {24'h0, cv | {3'h0, ef, 4'h0}});
         gie <= 1'h0;
         repeat (2) @(posedge clk);
         check("cmp gie", cirq, 1'h0);
         gie <= 1'h1;
         bus(1'h1, 3'h0, cv | 8'h10);
         @(posedge clk);
         check("cmp w1c", cirq, 1'h0);
         bus(1'h1, 3'h0, 8'h10 | m[7:0]);
      end
      ch1 = 3'($urandom());
      ch2 = ch1 + 3'h1;
      rf = 2'($urandom());
      la = 1'($urandom());
      r1 = 10'($urandom());
      r2 = 10'($urandom());
      bus(1'h1, 3'h1, 8'h08);
      bus(1'h1, 3'h2, {rf, la, 2'h0, ch1});
      @(posedge clk);
      check("neg mux", {nmux, nch}, {1'h1, ch1});
      check("sel off", {ref_o, ch_o}, 5'h00);
      res <= r1;
      bus(1'h1, 3'h3, 8'hC8);
      bus(1'h0, 3'h3, 8'h00);
      check("start", r[6], 1'h1);
      check("sel on", {ref_o, ch_o, nmux}, {rf, ch1, 1'h0});
      wait_busy(1'h1);
      wait_busy(1'h0);
      bus(1'h0, 3'h3, 8'h00);
      check("done", r, 32'h98);
      check("done irq", dirq, 1'h1);
      vtk <= 1'h1;
      @(posedge clk);
      vtk <= 1'h0;
      repeat (2) @(posedge clk);
      check("vector clear", dirq, 1'h0);
      bus(1'h0, 3'h4, 8'h00);
      check("low", r, rb(1'h0, la, r1));
      res <= r2;
      bus(1'h1, 3'h3, 8'hC8);
      wait_busy(1'h1);
      bus(1'h1, 3'h2, {rf, la, 2'h0, ch2});
      check("frozen", ch_o, ch1);
      wait_busy(1'h0);
      repeat (2) @(posedge clk);
      check("tracking", ch_o, ch2);
      bus(1'h0, 3'h3, 8'h00);
      check("done locked", r, 32'h98);
      bus(1'h0, 3'h5, 8'h00);
      check("high locked", r, rb(1'h1, la, r1));
      bus(1'h1, 3'h3, 8'hE8);
      repeat (80) @(posedge clk);
      bus(1'h0, 3'h3, 8'h00);
      check("free run", r & 32'hE0, 32'hE0);
      bus(1'h0, 3'h4, 8'h00);
      check("low new", r, rb(1'h0, la, r2));
      bus(1'h0, 3'h5, 8'h00);
      check("high new", r, rb(1'h1, la, r2));
      bus(1'h1, 3'h3, 8'h00);
      repeat (2) @(posedge clk);
      check("stopped", {busy, cclk, en_o}, 3'h0);
      for (int s = 0; s < 8; s++) begin
         bus(1'h1, 3'h3, 8'h80 | s[7:0]);
         @(negedge clk);
         wait_cclk(1'h0);
         wait_cclk(1'h1);
         p = 0;
         wait_cclk(1'h0);
         wait_cclk(1'h1);
         check("divider", p, 1 << (s < 2 ? 1 : s));
         @(posedge clk);
      end
      summarize();
   end
endmodule // acsc_top_bench
`default_nettype wire
